// ### shared/cmfc_pkg.sv
package cmfc_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] MODE_ADDR    = 8'h04;
  localparam logic [7:0] STATUS_ADDR  = 8'h08;
  localparam logic [7:0] IRQ_ST_ADDR  = 8'h0c;
  localparam logic [7:0] IRQ_MSK_ADDR = 8'h10;

  // Control register field positions
  localparam int DEPTH_LSB   = 16;
  localparam int DEPTH_MSB   = 20;
  localparam int FLUSH_BIT   = 14;
  localparam int ADV_BIT     = 13;
  localparam int PAYLOAD_BIT = 12;
  localparam int DIR_BIT     = 7;
  localparam int ABORT_BIT   = 6;
  localparam int ARBL_BIT    = 5;
  localparam int SERR_BIT    = 4;

  // Operating mode field
  localparam int           MODE_W       = 3;
  localparam logic [2:0]   MODE_CONFIG  = 3'h4;
  localparam logic [2:0]   MODE_RESET   = 3'h4;

  // Reset values
  localparam logic [4:0]   DEPTH_RESET  = 5'h00;
  localparam logic [4:0]   PTR_RESET    = 5'h00;
  localparam int           FLUSH_CYCLES = 2;

  // Interrupt status bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ABORT  = 1;
  localparam int IRQ_ARBL   = 2;
  localparam int IRQ_SERR   = 3;

  // Outcome of one transmission reported by the protocol engine
  typedef struct packed {
    logic done;
    logic aborted;
    logic arb_lost;
    logic send_error;
  } cmfc_tx_event_t;

endpackage : cmfc_pkg

// ### design/cmfc_fifo_ctrl.sv
// Contract
// - Depth code plus one gives message capacity
// - Flush bit resets FIFO, self clears
// - Transmit FIFO advance moves head one
// - Receive FIFO advance moves tail one
// - Payload-only applies to receive FIFOs only
// - Direction bit set means transmit FIFO
// - Depth, payload-only writable only in config mode
// - Abort flag updates on completion or flush
// - Arbitration/error flags clear on read, flush
// - Unimplemented bits read zero, ignore writes
`timescale 1ns/100ps
module cmfc_fifo_ctrl (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire cmfc_pkg::cmfc_tx_event_t tx_event_i,
  input  wire logic                    msg_stored_i,
  output logic      [4:0]              head_ptr_o,
  output logic      [4:0]              tail_ptr_o,
  output logic      [4:0]              depth_code_o,
  output logic                         direction_select_o,
  output logic                         payload_only_store_o,
  output logic                         flush_busy_o,
  output logic                         irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic        req;
  logic        wr;
  logic        rd;
  logic [31:0] rdata_nxt;
  logic        ack_r;
  logic [4:0]  depth_r;
  logic        flush_r;
  logic [1:0]  flush_cnt_r;
  logic        adv_r;
  logic        payload_r;
  logic        dir_r;
  logic        abort_r;
  logic        arbl_r;
  logic        serr_r;
  logic [1:0]  prio_r;
  logic        sreq_r;
  logic        rtr_r;
  logic [2:0]  mode_r;
  logic [4:0]  head_r;
  logic [4:0]  tail_r;
  logic [3:0]  irq_st_r;
  logic [3:0]  irq_msk_r;
  logic [3:0]  irq_set;
  logic        ctrl_wr;
  logic        ctrl_rd;
  logic        flush_done;

  assign req     = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr      = req && wb_we_i;
  assign rd      = req && !wb_we_i;
  assign ctrl_wr = wr && (wb_adr_i == cmfc_pkg::CTRL_ADDR);
  assign ctrl_rd = rd && (wb_adr_i == cmfc_pkg::CTRL_ADDR);

  // Capacity wraps at depth code plus one messages
  function automatic logic [4:0] wrap_inc(input logic [4:0] p, input logic [4:0] code);
    wrap_inc = (p == code) ? cmfc_pkg::PTR_RESET : p + 5'h01;
  endfunction : wrap_inc

  function automatic logic [31:0] ctrl_word();
    logic [31:0] w;
    w = 32'h0;
    w[cmfc_pkg::DEPTH_MSB:cmfc_pkg::DEPTH_LSB] = depth_r;
    w[cmfc_pkg::FLUSH_BIT]   = flush_r;
    w[cmfc_pkg::ADV_BIT]     = adv_r;
    w[cmfc_pkg::PAYLOAD_BIT] = payload_r;
    w[cmfc_pkg::DIR_BIT]     = dir_r;
    w[cmfc_pkg::ABORT_BIT]   = abort_r;
    w[cmfc_pkg::ARBL_BIT]    = arbl_r;
    w[cmfc_pkg::SERR_BIT]    = serr_r;
    w[3]                     = sreq_r;
    w[2]                     = rtr_r;
    w[1:0]                   = prio_r;
    ctrl_word = w;
  endfunction : ctrl_word

  always_comb begin
    if (wb_adr_i == cmfc_pkg::CTRL_ADDR) begin
      rdata_nxt = ctrl_word();
    end else if (wb_adr_i == cmfc_pkg::MODE_ADDR) begin
      rdata_nxt = {29'h0, mode_r};
    end else if (wb_adr_i == cmfc_pkg::STATUS_ADDR) begin
      rdata_nxt = {19'h0, flush_r, 2'h0, head_r, tail_r};
    end else if (wb_adr_i == cmfc_pkg::IRQ_ST_ADDR) begin
      rdata_nxt = {28'h0, irq_st_r};
    end else if (wb_adr_i == cmfc_pkg::IRQ_MSK_ADDR) begin
      rdata_nxt = {28'h0, irq_msk_r};
    end else begin
      rdata_nxt = 32'h0; // Unmapped reads zero, still acked
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_r    <= req;
      wb_dat_o <= rd ? rdata_nxt : 32'h0;
    end
  end
  assign wb_ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= cmfc_pkg::MODE_RESET;
    end else if (wr && wb_adr_i == cmfc_pkg::MODE_ADDR && wb_sel_i[0]) begin
      mode_r <= wb_dat_i[cmfc_pkg::MODE_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth_r   <= cmfc_pkg::DEPTH_RESET;
      payload_r <= 1'b0;
    end else if (ctrl_wr && mode_r == cmfc_pkg::MODE_CONFIG) begin
      if (wb_sel_i[2]) begin
        depth_r <= wb_dat_i[cmfc_pkg::DEPTH_MSB:cmfc_pkg::DEPTH_LSB];
      end
      if (wb_sel_i[1]) begin
        payload_r <= wb_dat_i[cmfc_pkg::PAYLOAD_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_r  <= 1'b0;
      sreq_r <= 1'b0;
      rtr_r  <= 1'b0;
      prio_r <= 2'h0;
    end else if (ctrl_wr && wb_sel_i[0]) begin
      dir_r  <= wb_dat_i[cmfc_pkg::DIR_BIT];
      rtr_r  <= wb_dat_i[2];
      prio_r <= wb_dat_i[1:0];
      sreq_r <= wb_dat_i[3];
    end else if (tx_event_i.done || tx_event_i.aborted) begin
      sreq_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flush sequence
  assign flush_done = flush_r && (flush_cnt_r == 2'(cmfc_pkg::FLUSH_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_r     <= 1'b0;
      flush_cnt_r <= 2'h0;
    end else if (flush_r) begin
      flush_cnt_r <= flush_cnt_r + 2'h1;
      if (flush_done) begin
        flush_r     <= 1'b0;
        flush_cnt_r <= 2'h0;
      end
    end else if (ctrl_wr && wb_sel_i[1] && wb_dat_i[cmfc_pkg::FLUSH_BIT]) begin
      flush_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_r <= 1'b0;
    end else begin
      adv_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_done) begin
      head_r <= cmfc_pkg::PTR_RESET;
      tail_r <= cmfc_pkg::PTR_RESET;
    end else if (!flush_r) begin
      if (ctrl_wr && wb_sel_i[1] && wb_dat_i[cmfc_pkg::ADV_BIT]) begin
        if (dir_r) begin
          head_r <= wrap_inc(head_r, depth_r);
        end else begin
          tail_r <= wrap_inc(tail_r, depth_r);
        end
      end
      if (dir_r && tx_event_i.done) begin
        tail_r <= wrap_inc(tail_r, depth_r);
      end else if (!dir_r && msg_stored_i) begin
        head_r <= wrap_inc(head_r, depth_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit status flags
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_done) begin
      abort_r <= 1'b0;
    end else if (tx_event_i.done || tx_event_i.aborted) begin
      abort_r <= tx_event_i.aborted;
    end
  end

  // Hardware set wins over the read clear
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_done) begin
      arbl_r <= 1'b0;
      serr_r <= 1'b0;
    end else begin
      arbl_r <= tx_event_i.arb_lost || (arbl_r && !ctrl_rd);
      serr_r <= tx_event_i.send_error || (serr_r && !ctrl_rd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  assign irq_set = {tx_event_i.send_error, tx_event_i.arb_lost,
                    tx_event_i.aborted, tx_event_i.done};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_r  <= 4'h0;
      irq_msk_r <= 4'h0;
      irq_o     <= 1'b0;
    end else begin
      if (wr && wb_adr_i == cmfc_pkg::IRQ_ST_ADDR && wb_sel_i[0]) begin
        irq_st_r <= irq_set | (irq_st_r & ~wb_dat_i[3:0]);
      end else begin
        irq_st_r <= irq_set | irq_st_r;
      end
      if (wr && wb_adr_i == cmfc_pkg::IRQ_MSK_ADDR && wb_sel_i[0]) begin
        irq_msk_r <= wb_dat_i[3:0];
      end
      irq_o <= |(irq_st_r & irq_msk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_ptr_o           <= 5'h00;
      tail_ptr_o           <= 5'h00;
      depth_code_o         <= 5'h00;
      direction_select_o   <= 1'b0;
      payload_only_store_o <= 1'b0;
      flush_busy_o         <= 1'b0;
    end else begin
      head_ptr_o           <= head_r;
      tail_ptr_o           <= tail_r;
      depth_code_o         <= depth_r;
      direction_select_o   <= dir_r;
      payload_only_store_o <= payload_r && !dir_r;
      flush_busy_o         <= flush_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_flush_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flush_r) |-> ##[1:3] !flush_r) else $error("flush not cleared");
  a_flush_ptrs: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(flush_r) |-> head_r == 5'h00 && tail_r == 5'h00 && !arbl_r)
    else $error("flush left state");
  a_head_step: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && wb_sel_i[1] && wb_dat_i[13] && dir_r && !flush_r
    |=> head_r == wrap_inc($past(head_r), depth_r)) else $error("head step");
  a_tail_step: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && wb_sel_i[1] && wb_dat_i[13] && !dir_r && !flush_r
    |=> tail_r == wrap_inc($past(tail_r), depth_r)) else $error("tail step");
  a_ptr_range: assert property (@(posedge clk_i) disable iff (rst_i)
    head_r <= depth_r || $changed(depth_r) || mode_r == 3'h4)
    else $error("head beyond depth");
  a_depth_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(mode_r) != 3'h4 |-> $stable(depth_r) && $stable(payload_r))
    else $error("depth changed outside config");
  a_arbl_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_rd && !tx_event_i.arb_lost && !flush_done |=> !arbl_r)
    else $error("arb flag not cleared");
  a_abort_upd: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_event_i.aborted && !flush_done |=> abort_r) else $error("abort flag");
  a_adv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(ctrl_rd) |-> wb_dat_o[31:21] == 11'h0 && wb_dat_o[15] == 1'b0
    && wb_dat_o[13] == 1'b0 && wb_dat_o[11:8] == 4'h0)
    else $error("reserved bits set");
  a_payload_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    direction_select_o |-> !payload_only_store_o) else $error("payload in tx");
  a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && wb_sel_i[0] |=> dir_r == $past(wb_dat_i[7])) else $error("dir");

  c_flush: cover property (@(posedge clk_i) $fell(flush_r));
  c_head_wrap: cover property (@(posedge clk_i) dir_r && head_r == depth_r ##1 head_r == 5'h00);
  c_tail_adv: cover property (@(posedge clk_i) !dir_r && $changed(tail_r));
  c_irq: cover property (@(posedge clk_i) $rose(irq_o));

endmodule : cmfc_fifo_ctrl

// ### tb/cmfc_engine_model.sv
`timescale 1ns/100ps
module cmfc_engine_model (
  input  wire logic                clk_i,
  output cmfc_pkg::cmfc_tx_event_t tx_event_o,
  output logic                     msg_stored_o
);
  initial begin
    tx_event_o   = '0;
    msg_stored_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // One-cycle outcome pulse after dly edges; dly sets prompt or slow
  task send(input logic [3:0] ev, input int dly, input logic st);
    repeat (dly) @(posedge clk_i);
    tx_event_o   <= ev;
    msg_stored_o <= st;
    @(posedge clk_i);
    tx_event_o   <= '0;
    msg_stored_o <= 1'b0;
  endtask : send
endmodule : cmfc_engine_model

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] CA = cmfc_pkg::CTRL_ADDR;
  localparam logic [7:0] MA = cmfc_pkg::MODE_ADDR;
  localparam logic [7:0] SA = cmfc_pkg::IRQ_ST_ADDR;
  localparam logic [7:0] KA = cmfc_pkg::IRQ_MSK_ADDR;
  logic                     clk_i;
  logic                     rst_i;
  logic                     cyc;
  logic                     stb;
  logic                     we;
  logic [7:0]               adr;
  logic [3:0]               sel;
  logic [31:0]              dat;
  logic [31:0]              wb_dat_o;
  logic                     wb_ack_o;
  cmfc_pkg::cmfc_tx_event_t ev;
  logic                     st;
  logic [4:0]               head_ptr_o;
  logic [4:0]               tail_ptr_o;
  logic [4:0]               depth_code_o;
  logic                     dir_o;
  logic                     pay_o;
  logic                     irq_o;
  logic                     fb_o;
  logic [31:0]              q;
  logic [31:0]              rows [0:4][0:3];
  int                       bad_count;
  int                       check_count;
  int                       cyc_n;

  cmfc_fifo_ctrl u_cmfc_fifo_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_event_i(ev), .msg_stored_i(st),
    .head_ptr_o(head_ptr_o), .tail_ptr_o(tail_ptr_o), .depth_code_o(depth_code_o),
    .direction_select_o(dir_o), .payload_only_store_o(pay_o), .flush_busy_o(fb_o),
    .irq_o(irq_o));
  cmfc_engine_model u_cmfc_engine_model (.clk_i(clk_i), .tx_event_o(ev),
    .msg_stored_o(st));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // Holds the request until ack is sampled; read data lands in q
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) bad_count++;
  endtask : wb
  task cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cy
  task ptrs(input logic [4:0] h, input logic [4:0] t);
    cy(2);
    chk("head", {27'h0, head_ptr_o}, {27'h0, h});
    chk("tail", {27'h0, tail_ptr_o}, {27'h0, t});
  endtask : ptrs
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    dat = 32'h0;
    bad_count = 0;
    check_count = 0;
    cyc_n = 0;
    // Write value, read mask, expected read, expected payload output
    rows = '{'{32'hffe0_8f00, 32'hffff_ffff, 32'h0, 32'h0},
             '{32'h0000_007f, 32'hffff_ffff, 32'h0000_000f, 32'h0},
             '{32'h001f_0080, 32'hffff_ffff, 32'h001f_0080, 32'h0},
             '{32'h0000_1000, 32'hffff_ffff, 32'h0000_1000, 32'h1},
             '{32'h0000_1080, 32'hffff_efff, 32'h0000_0080, 32'h0}};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CA, 32'h0);
    chk("ctrl_rst", q, 32'h0);
    wb(1'b0, MA, 32'h0);
    chk("mode_rst", q, {29'h0, cmfc_pkg::MODE_RESET});
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, CA, rows[i][0]);
      cy(2);
      wb(1'b0, CA, 32'h0);
      chk("ctrl", q & rows[i][1], rows[i][2]);
      chk("depth", {27'h0, depth_code_o}, {27'h0, rows[i][2][20:16]});
      chk("dir", {31'h0, dir_o}, {31'h0, rows[i][2][7]});
      chk("payload", {31'h0, pay_o}, rows[i][3]);
    end
    $display("table test done");
    wb(1'b1, MA, 32'h0);
    wb(1'b1, CA, 32'h0005_0000);
    cy(2);
    chk("depth_lock", {27'h0, depth_code_o}, 32'h0);
    chk("payload_lock", {31'h0, pay_o}, 32'h1);
    wb(1'b1, MA, 32'h4);
    // Depth lane disabled: the field must keep its value
    sel <= 4'h3;
    wb(1'b1, CA, 32'h0007_0000);
    sel <= 4'hf;
    cy(2);
    chk("depth_lane", {27'h0, depth_code_o}, 32'h0);
    $display("mode test done");
    // Capacity three: head wraps back to zero on the third advance
    wb(1'b1, CA, 32'h0002_0080);
    for (int i = 1; i <= 3; i++) begin
      wb(1'b1, CA, 32'h0002_2080);
      ptrs(5'(i % 3), 5'h0);
    end
    wb(1'b0, CA, 32'h0);
    chk("adv_rd", q & 32'h2000, 32'h0);
    // Direction switched first: the advance acts on the direction already held
    wb(1'b1, CA, 32'h0002_0000);
    ptrs(5'h0, 5'h0);
    wb(1'b1, CA, 32'h0002_2000);
    ptrs(5'h0, 5'h1);
    u_cmfc_engine_model.send(4'h0, 1, 1'b1);
    ptrs(5'h1, 5'h1);
    wb(1'b0, cmfc_pkg::STATUS_ADDR, 32'h0);
    chk("status", q, 32'h0000_0021);
    $display("pointer test done");
    u_cmfc_engine_model.send(4'h3, 3, 1'b0);
    u_cmfc_engine_model.send(4'hc, 1, 1'b0);
    cy(1);
    wb(1'b0, CA, 32'h0);
    chk("flags", q & 32'h70, 32'h70);
    wb(1'b0, CA, 32'h0);
    chk("flags_rd", q & 32'h70, 32'h40);
    wb(1'b1, KA, 32'h0);
    wb(1'b0, SA, 32'h0);
    chk("irq_st", q, 32'hf);
    cy(2);
    chk("irq_off", {31'h0, irq_o}, 32'h0);
    wb(1'b1, KA, 32'h2);
    cy(2);
    chk("irq_on", {31'h0, irq_o}, 32'h1);
    wb(1'b1, SA, 32'h2);
    cy(2);
    chk("irq_clr", {31'h0, irq_o}, 32'h0);
    wb(1'b0, SA, 32'h0);
    chk("irq_st2", q, 32'hd);
    $display("event test done");
    u_cmfc_engine_model.send(4'h2, 1, 1'b0);
    cy(1);
    wb(1'b1, CA, 32'h0002_4000);
    cy(1);
    chk("flush_busy", {31'h0, fb_o}, 32'h1);
    // Software side must poll until the flush bit drops; always reads once
    for (int n = 0; n < 20 && (n == 0 || q[14] !== 1'b0); n++) wb(1'b0, CA, 32'h0);
    chk("flush_bit", q & 32'h4000, 32'h0);
    ptrs(5'h0, 5'h0);
    chk("flush_idle", {31'h0, fb_o}, 32'h0);
    wb(1'b0, CA, 32'h0);
    chk("flush_flags", q & 32'h70, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("flush test done");
    results();
  end
endmodule : tb
